// [common/trim_map.vh]
`ifndef TRIM_MAP_VH
`define TRIM_MAP_VH

// register offsets on the plain register port
`define TRIM_ADDR_CTRL1 8'h60
`define TRIM_ADDR_CTRL2 8'h61
`define TRIM_ADDR_IRQ_STATUS 8'h62
`define TRIM_ADDR_IRQ_ENABLE 8'h63
`define TRIM_ADDR_IRQ_CLEAR 8'h64

// first control/status register fields
`define TRIM_FULL_BIT 6
`define TRIM_SHORTEN_BIT 5
`define TRIM_RING_BIT 4
`define TRIM_TIP_BIT 3
`define TRIM_DIFF_BIT 2
`define TRIM_CM_BIT 1
`define TRIM_LIMIT_BIT 0

// second control/status register fields
`define TRIM_MON1_BIT 4
`define TRIM_MON2_BIT 3
`define TRIM_AUDIO_DAC_BIT 2
`define TRIM_AUDIO_ADC_BIT 1

// step vector positions (0..4 mirror the first register)
`define TRIM_NUM_STEPS 9
`define TRIM_STEP_AUDIO_ADC 5
`define TRIM_STEP_AUDIO_DAC 6
`define TRIM_STEP_MON2 7
`define TRIM_STEP_MON1 8

// interrupt event positions
`define TRIM_NUM_EVENTS 3
`define TRIM_EV_FULL_DONE 0
`define TRIM_EV_STEP_DONE 1
`define TRIM_EV_DAC_DONE 2

// reset values
`define TRIM_CTRL_RESET 8'h00
`define TRIM_STEPS_RESET 9'h000
`define TRIM_IRQ_RESET 3'h0

// settle timing
`define TRIM_SETTLE_LONG_MS 300
`define TRIM_SETTLE_SHORT_MS 30
`define TRIM_CLK_KHZ 125000

`endif

// [hdl/trim_control_status.v]
// Function
// - full-trim bit starts every calibration step
// - full-trim bit reads one while running
// - shorten bit picks 30 ms, else 300 ms
// - bit 4 runs ring gain trim
// - bit 3 runs tip gain trim
// - bit 2 runs differential dac trim
// - bit 1 runs common-mode dac trim
// - second register bit 2 runs audio dac trim
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "trim_map.vh"

module trim_control_status #(
  parameter NUM_STEPS = `TRIM_NUM_STEPS,
  // settle counts in clock cycles; shorten for simulation
  // the product of ms and kHz gives cycles at the real clock
  parameter [31:0] SETTLE_LONG_CYCLES = `TRIM_SETTLE_LONG_MS * `TRIM_CLK_KHZ,
  parameter [31:0] SETTLE_SHORT_CYCLES = `TRIM_SETTLE_SHORT_MS * `TRIM_CLK_KHZ
) (
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // analog trim engine handshake
  output reg [NUM_STEPS-1:0] trim_step,
  input wire step_done,
  output reg settle_active,
  // interrupt
  output reg irq
);

  // fsm states
  // idle picks the next job, settle waits for the battery,
  // issue hands one step out, wait holds it until done
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_ISSUE = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;

  // all steps at once, used by the full run
  // monitor and audio steps ride along with the line steps
  localparam [NUM_STEPS-1:0] ALL_STEPS = {NUM_STEPS{1'b1}};

  // picks the lowest pending step as a one-hot mask
  // a plain loop; nine steps keep the priority chain short
  function [NUM_STEPS-1:0] lowest_step;
    input [NUM_STEPS-1:0] vec;
    integer i;
    reg found;
    begin
      lowest_step = {NUM_STEPS{1'b0}};
      found = 1'b0;
      for (i = 0; i < NUM_STEPS; i = i + 1)
      begin
        if (vec[i] && !found)
        begin
          lowest_step[i] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  // one register port access aimed at a given offset;
  // shared by every write decode so they cannot drift apart
  function reg_hit;
    input strobe;
    input [7:0] where;
    input [7:0] offset;
    begin
      reg_hit = strobe && (where == offset);
    end
  endfunction

  // settle length for a full run, chosen by the speed-up option
  function [31:0] settle_load;
    input short_sel;
    begin
      if (short_sel)
        settle_load = SETTLE_SHORT_CYCLES;
      else
        settle_load = SETTLE_LONG_CYCLES;
    end
  endfunction

  // control state
  // pend is what software reads back; a bit drops only on done
  reg [1:0] state; // sequencer state
  reg [1:0] next_state;
  reg [NUM_STEPS-1:0] pend; // enabled or running steps
  reg [NUM_STEPS-1:0] next_pend;
  reg [NUM_STEPS-1:0] cur; // step now handed to the engine
  reg [NUM_STEPS-1:0] next_cur;
  reg full_run; // whole-system trim in progress
  reg next_full_run;
  reg settle_req; // full run still owes its settle wait
  reg next_settle_req;
  reg shorten; // settle speed-up option
  reg [31:0] settle_cnt; // cycles left in settle wait
  reg [31:0] next_settle_cnt;

  // interrupt registers
  // three events only: full done, any step done, audio dac done
  reg [`TRIM_NUM_EVENTS-1:0] irq_status; // sticky events
  reg [`TRIM_NUM_EVENTS-1:0] irq_enable; // event mask
  reg [`TRIM_NUM_EVENTS-1:0] ev; // events raised this cycle
  reg [`TRIM_NUM_EVENTS-1:0] next_irq_status;

  // decoded writes
  // status is read-only, so it has no write decode
  wire wr_ctrl1 = reg_hit(wr, addr, `TRIM_ADDR_CTRL1);
  wire wr_ctrl2 = reg_hit(wr, addr, `TRIM_ADDR_CTRL2);
  wire wr_enable = reg_hit(wr, addr, `TRIM_ADDR_IRQ_ENABLE);
  wire wr_clear = reg_hit(wr, addr, `TRIM_ADDR_IRQ_CLEAR);

  // steps that software asks for in this cycle
  // one bit per step, same layout as pend
  reg [NUM_STEPS-1:0] write_set;

  // register images as software sees them
  // reserved bits are tied low here, not stored
  wire [7:0] ctrl1_image;
  wire [7:0] ctrl2_image;

  // bit 7 of the first register reads zero
  assign ctrl1_image = {1'b0, full_run, shorten, pend[`TRIM_RING_BIT], pend[`TRIM_TIP_BIT],
    pend[`TRIM_DIFF_BIT], pend[`TRIM_CM_BIT], pend[`TRIM_LIMIT_BIT]};

  // bits 7:5 and 0 of the second register read zero
  assign ctrl2_image = {3'h0, pend[`TRIM_STEP_MON1], pend[`TRIM_STEP_MON2],
    pend[`TRIM_STEP_AUDIO_DAC], pend[`TRIM_STEP_AUDIO_ADC], 1'b0};

  // gather the step-enable bits written this cycle
  // a written zero never cancels a step: the analog side
  // cannot be stopped cleanly half way through a trim
  always @*
  begin
    write_set = {NUM_STEPS{1'b0}};
    if (wr_ctrl1)
    begin
      if (wdata[`TRIM_FULL_BIT])
        write_set = ALL_STEPS;
      write_set[`TRIM_RING_BIT] = write_set[`TRIM_RING_BIT] | wdata[`TRIM_RING_BIT];
      write_set[`TRIM_TIP_BIT] = write_set[`TRIM_TIP_BIT] | wdata[`TRIM_TIP_BIT];
      write_set[`TRIM_DIFF_BIT] = write_set[`TRIM_DIFF_BIT] | wdata[`TRIM_DIFF_BIT];
      write_set[`TRIM_CM_BIT] = write_set[`TRIM_CM_BIT] | wdata[`TRIM_CM_BIT];
      write_set[`TRIM_LIMIT_BIT] = write_set[`TRIM_LIMIT_BIT] | wdata[`TRIM_LIMIT_BIT];
    end
    if (wr_ctrl2)
    begin
      write_set[`TRIM_STEP_MON1] = wdata[`TRIM_MON1_BIT];
      write_set[`TRIM_STEP_MON2] = wdata[`TRIM_MON2_BIT];
      write_set[`TRIM_STEP_AUDIO_DAC] = wdata[`TRIM_AUDIO_DAC_BIT];
      write_set[`TRIM_STEP_AUDIO_ADC] = wdata[`TRIM_AUDIO_ADC_BIT];
    end
  end

  // sequencer next-state logic
  // steps run one at a time, lowest index first, so the
  // engine never sees two requests and the order is fixed
  always @*
  begin
    next_state = state;
    next_pend = pend;
    next_cur = cur;
    next_full_run = full_run;
    next_settle_req = settle_req;
    next_settle_cnt = settle_cnt;
    ev = `TRIM_IRQ_RESET;
    case (state)
      ST_IDLE:
      begin
        if (settle_req)
        begin
          // battery settle before the first full-run step
          // individual steps skip this wait entirely
          next_settle_req = 1'b0;
          next_settle_cnt = settle_load(shorten);
          next_state = ST_SETTLE;
        end
        else if (|pend)
          next_state = ST_ISSUE;
        else if (full_run)
        begin
          // every step finished: full run is over
          next_full_run = 1'b0;
          ev[`TRIM_EV_FULL_DONE] = 1'b1;
        end
      end
      ST_SETTLE:
      begin
        // count down; a zero count still costs one cycle
        // the length is fixed once loaded; no restart mid-wait
        if (settle_cnt <= 32'h0000_0001)
        begin
          next_settle_cnt = 32'h0000_0000;
          next_state = ST_ISSUE;
        end
        else
          next_settle_cnt = settle_cnt - 32'h0000_0001;
      end
      ST_ISSUE:
      begin
        // hand the lowest pending step to the engine
        // an empty queue drops straight back to idle
        next_cur = lowest_step(pend);
        if (|pend)
          next_state = ST_WAIT;
        else
          next_state = ST_IDLE;
      end
      ST_WAIT:
      begin
        if (step_done)
        begin
          // step complete: its bit falls to zero
          // a done pulse with no request out never reaches here
          next_pend = pend & ~cur;
          next_cur = {NUM_STEPS{1'b0}};
          ev[`TRIM_EV_STEP_DONE] = 1'b1;
          ev[`TRIM_EV_DAC_DONE] = cur[`TRIM_STEP_AUDIO_DAC];
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_cur = {NUM_STEPS{1'b0}};
      end
    endcase
    // a new request beats a completion in the same cycle
    // a full-run write also queues a fresh settle wait
    next_pend = next_pend | write_set;
    if (wr_ctrl1 && wdata[`TRIM_FULL_BIT])
    begin
      next_full_run = 1'b1;
      next_settle_req = 1'b1;
    end
  end

  // sticky status: set wins over a same-cycle clear
  // so an event is never lost to a clear that raced it
  always @*
  begin
    next_irq_status = irq_status;
    if (wr_clear)
      next_irq_status = irq_status & ~wdata[`TRIM_NUM_EVENTS-1:0];
    next_irq_status = next_irq_status | ev;
  end

  // sequencer and control registers
  // synchronous reset only; every register but shorten loads each edge
  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      pend <= `TRIM_STEPS_RESET;
      cur <= `TRIM_STEPS_RESET;
      full_run <= 1'b0;
      settle_req <= 1'b0;
      settle_cnt <= 32'h0000_0000;
      shorten <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pend <= next_pend;
      cur <= next_cur;
      full_run <= next_full_run;
      settle_req <= next_settle_req;
      settle_cnt <= next_settle_cnt;
      // option latched at settle start; later writes act next run
      // plain read/write bit, not a start bit
      if (wr_ctrl1)
        shorten <= wdata[`TRIM_SHORTEN_BIT];
    end
  end

  // engine-facing outputs, straight from flip-flops
  // built from next values so requests leave with no lag
  always @(posedge clk)
  begin
    if (rst)
    begin
      trim_step <= `TRIM_STEPS_RESET;
      settle_active <= 1'b0;
    end
    else
    begin
      trim_step <= next_cur;
      settle_active <= (next_state == ST_SETTLE);
    end
  end

  // interrupt registers and level output
  // a new enable mask counts at once, not one edge late
  always @(posedge clk)
  begin
    if (rst)
    begin
      irq_status <= `TRIM_IRQ_RESET;
      irq_enable <= `TRIM_IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_enable)
        irq_enable <= wdata[`TRIM_NUM_EVENTS-1:0];
      // follows status in the same edge, no extra lag
      if (wr_enable)
        irq <= |(next_irq_status & wdata[`TRIM_NUM_EVENTS-1:0]);
      else
        irq <= |(next_irq_status & irq_enable);
    end
  end

  // read port: data valid the cycle after the strobe only
  // idle cycles return zero so a stale value never lingers
  always @(posedge clk)
  begin
    if (rst)
      rdata <= `TRIM_CTRL_RESET;
    else if (rd)
    begin
      case (addr)
        `TRIM_ADDR_CTRL1: rdata <= ctrl1_image;
        `TRIM_ADDR_CTRL2: rdata <= ctrl2_image;
        `TRIM_ADDR_IRQ_STATUS: rdata <= {5'h00, irq_status};
        `TRIM_ADDR_IRQ_ENABLE: rdata <= {5'h00, irq_enable};
        // clear register is write-only; unmapped reads zero
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule // trim_control_status
`default_nettype wire

// [test/trim_control_status_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module trim_checker #(
  parameter NUM_STEPS = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [NUM_STEPS-1:0] trim_step,
  input wire logic step_done,
  input wire logic settle_active,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // engine currently holds a request
  wire busy = trim_step != 0;
  // write to the first control register
  wire w1 = wr && addr == 8'h60;
  // idle engine, so a new request has no queue ahead of it
  wire quiet = !busy && !settle_active;
  // any write that can queue a step or a settle wait
  wire wctl = wr && (addr == 8'h60 || addr == 8'h61);
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
  one_hot_a: assert property (
    $onehot0(trim_step)) else $error("more than one step");
  step_hold_a: assert property (
    busy && !step_done |=> $stable(trim_step)) else $error("step dropped early");
  step_drop_a: assert property (
    busy && step_done |=> !busy) else $error("step kept after done");
  settle_quiet_a: assert property (
    settle_active |-> !busy) else $error("step during settle");
  full_start_a: assert property (
    w1 && wdata[6] && quiet && !$past(busy) && !$past(busy, 2) && !$past(wctl) && !$past(wctl, 2)
      && !$past(settle_active) |-> ##[1:4] settle_active) else $error("full run not started");
  single_start_a: assert property (
    w1 && wdata == 8'h01 && quiet && !$past(busy) && !$past(busy, 2) && !$past(wctl) && !$past(wctl, 2)
      && !$past(settle_active) |-> ##[2:4] trim_step == 1) else $error("limit step not issued");
  clear_zero_a: assert property (
    rd && addr == 8'h64 |=> rdata == 8'h00) else $error("clear register not zero");
  settle_c: cover property (settle_active);
  done_c: cover property (busy && step_done);
  irq_c: cover property (irq);
endmodule // trim_checker
bind trim_control_status trim_checker #(.NUM_STEPS(NUM_STEPS)) u_chk (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trim_step(trim_step),
  .step_done(step_done), .settle_active(settle_active), .irq(irq));
`default_nettype wire

// [test/test_trim_control_status.sv]
`timescale 1ns/1ps
`default_nettype none
module test_trim_control_status;
  logic clk = 0, rst = 1, wr = 0, rd = 0, step_done = 0, go = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] ra, dv;
  wire [7:0] rdata;
  wire [8:0] trim_step;
  wire settle_active, irq;
  int n_errors = 0, tests_run = 0, n_seen = 0, cyc = 0, i, k, cnt;
  // short settle counts keep the run brief
  trim_control_status #(.SETTLE_LONG_CYCLES(20), .SETTLE_SHORT_CYCLES(5)) u_dut (.clk(clk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trim_step(trim_step), .step_done(step_done), .settle_active(settle_active), .irq(irq));
  initial forever #4 clk = ~clk;
  task cmp(input [15:0] got, input [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  // data stand only in the cycle after the strobe
  task rd_reg(input [7:0] a, input [7:0] exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 cmp(rdata, exp);
  endtask
  // let the engine answer until the interrupt rises, bounded
  task run_irq;
    @(posedge clk);
    go <= 1;
    for (i = 0; i < 400 && irq !== 1; i++)
    begin
      @(posedge clk);
      #1;
    end
    go <= 0;
    cmp(irq, 1);
  endtask
  // engine model: done pulse one cycle after each request appears
  always @(posedge clk)
  begin
    step_done <= go && trim_step != 0 && !step_done;
    if (!rst && step_done && trim_step != 0)
    begin
      cmp(trim_step, 16'h1 << n_seen);
      n_seen++;
    end
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      close_out;
    end
  end
  // full run: settle length, readback while pending, order of all steps
  task full(input [7:0] sp, input int n);
    wr_reg(8'h60, 8'h40 | sp);
    for (i = 0; i < 50 && settle_active !== 1; i++)
    begin
      @(posedge clk);
      #1;
    end
    for (cnt = 0; settle_active === 1 && cnt < 400; cnt++)
    begin
      @(posedge clk);
      #1;
    end
    cmp(cnt, n);
    rd_reg(8'h60, 8'h5F | sp);
    rd_reg(8'h61, 8'h1E);
    n_seen = 0;
    run_irq;
    cmp(n_seen, 9);
    rd_reg(8'h60, sp);
    wr_reg(8'h64, 8'h07);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    rd_reg(8'h60, 8'h00);
    rd_reg(8'h61, 8'h00);
    rd_reg(8'h62, 8'h00);
    rd_reg(8'h70, 8'h00);
    wr_reg(8'h63, 8'h02);
    rd_reg(8'h63, 8'h02);
    // each single step of both registers; a written zero must not cancel it
    for (k = 0; k < 9; k++)
    begin
      ra = k < 5 ? 8'h60 : 8'h61;
      dv = k < 5 ? 8'h01 << k : 8'h01 << (k - 4);
      wr_reg(ra, dv);
      repeat (5) @(posedge clk);
      #1 cmp(trim_step, 16'h1 << k);
      wr_reg(ra, 8'h00);
      rd_reg(ra, dv);
      n_seen = k;
      run_irq;
      rd_reg(ra, 8'h00);
      rd_reg(8'h62, k == 6 ? 8'h06 : 8'h02);
      wr_reg(8'h64, 8'h07);
      rd_reg(8'h62, 8'h00);
      cmp(irq, 0);
    end
    wr_reg(8'h63, 8'h01);
    full(8'h00, 20);
    full(8'h20, 5);
    rd_reg(8'h64, 8'h00);
    close_out;
  end
endmodule // test_trim_control_status
`default_nettype wire
